// ### design/cgs_guard.sv
// Configuration lock, checksum supervision and status/interrupt logic
`timescale 1ns/100ps
module cgs_guard
  import cgs_pkg::*;
#(
  parameter int CKS_CYCLES = cgs_pkg::CKS_PERIOD_CYC  // Checksum interval, shortenable
) (
  input  wire logic       clk,               // Device clock
  input  wire logic       reset,             // Synchronous reset, active high
  input  wire logic       reg_wr,            // Register write strobe
  input  wire logic       reg_rd,            // Register read strobe
  input  wire logic [7:0] reg_addr,          // Register address
  input  wire logic [7:0] reg_wdata,         // Write data
  output logic      [7:0] reg_rdata,         // Read data, one cycle after strobe
  output logic      [7:0] burst_primary,     // Primary flags for long read
  output logic      [7:0] burst_secondary,   // Secondary flags for long read
  output logic      [7:0] cfg_out [cgs_pkg::NUM_CFG], // Configuration contents
  input  wire logic       chip_ready,        // Whole chip ready for waveform data
  input  wire logic       link_err,          // Barrier link error event
  input  wire logic [3:0] link_err_kind,     // Category of that error
  input  wire logic       fuse_err,          // Fuse memory fault event
  input  wire logic [7:0] secondary_events,  // Secondary status events
  input  wire logic [7:0] tertiary_events,   // Corrected internal error events
  output logic            irq_n              // Interrupt pin, active low
);
  import cgs_pkg::*;

  // State registers
  // Each group has its next value computed in one combinational block
  logic [7:0]  cfg_reg [NUM_CFG];  // Configuration registers 0x01..0x1F
  logic [7:0]  cfg_next [NUM_CFG];
  logic        locked_reg, locked_next;       // Protection active
  logic        force_reg, force_next;         // Force request bit
  logic [15:0] cks_reg, cks_next;             // Stored checksum
  logic [15:0] acc_reg, acc_next;             // Running checksum
  logic [4:0]  idx_reg, idx_next;             // Register walked by checksum
  logic        first_reg, first_next;         // Next result is the reset default
  logic [31:0] tmr_reg, tmr_next;             // Interval timer
  logic [7:0]  st0_reg, st0_next;             // Primary flags
  logic [7:0]  st1_reg, st1_next;             // Secondary flags
  logic [7:0]  st2_reg, st2_next;             // Tertiary flags
  logic [7:0]  m0_reg, m0_next;               // Primary enables
  logic [7:0]  m1_reg, m1_next;               // Secondary enables
  logic [7:0]  m2_reg, m2_next;               // Tertiary enables
  logic [3:0]  ftype_reg, ftype_next;         // Fault category
  logic [7:0]  fcnt_reg, fcnt_next;           // Fault tally
  logic        rstd_reg, rstd_next;           // Reset just released
  logic [7:0]  rdata_reg, rdata_next;         // Read data
  logic        irq_n_reg, irq_n_next;         // Pin level

  // Checksum FSM with Gray-coded states
  // IDLE to RUN to DONE changes one bit per step
  typedef enum logic [1:0] {
    CKS_IDLE = 2'b00,  // Waiting for timer or force
    CKS_RUN  = 2'b01,  // Walking the registers
    CKS_DONE = 2'b11   // Storing result
  } cgs_cks_state_type;
  cgs_cks_state_type state_reg, state_next;

  // One byte step of CRC-16, polynomial from the package
  // Bits enter most significant first; a host model of the checksum
  // must walk the bytes in the same order and with the same seed
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CKS_POLY) : (r << 1);
    end
    return r;
  endfunction

  // Configuration register writes per entry
  // Entry 30 stands for the lock address and is never written here;
  // the lock key lives in its own flag and is folded into the checksum
  // Protected entries drop a locked write silently, with no error flag
  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g++) begin : g_cfg
      localparam logic [7:0] A = 8'(g + 1);
      always_comb begin
        cfg_next[g] = cfg_reg[g];
        if (reg_wr && reg_addr == A && A != ADDR_LOCK &&
            !(locked_reg && A >= ADDR_CFG_FIRST && A <= ADDR_CFG_PROT_END)) begin
          cfg_next[g] = reg_wdata;
        end
      end
      always_ff @(posedge clk) begin
        if (reset) cfg_reg[g] <= 8'h00;
        else       cfg_reg[g] <= cfg_next[g];
      end
      assign cfg_out[g] = cfg_reg[g];
    end
  endgenerate

  // The engine reads one register per cycle, so a write landing during a
  // run may be seen or missed depending on the entry already passed
  // Byte fed to checksum; lock register counted as its readback key
  logic [7:0] cks_byte;
  always_comb begin
    if (idx_reg == 5'(NUM_CFG - 1)) cks_byte = locked_reg ? KEY_LOCK : KEY_UNLOCK;
    else                            cks_byte = cfg_reg[idx_reg];
  end

  // Next state of lock, checksum, status and masks
  // Every next value but rstd_next starts from its register so that no path leaves a
  // latch; later assignments in this block take priority over earlier ones
  always_comb begin
    logic        wr_st;
    logic [7:0]  s1x, s2x;
    wr_st      = reg_wr;
    s1x        = 8'h00;
    s2x        = 8'h00;
    locked_next = locked_reg;
    force_next  = force_reg;
    cks_next    = cks_reg;
    acc_next    = acc_reg;
    idx_next    = idx_reg;
    first_next  = first_reg;
    tmr_next    = tmr_reg;
    state_next  = state_reg;
    st0_next    = st0_reg;
    st1_next    = st1_reg;
    st2_next    = st2_reg;
    m0_next     = m0_reg;
    m1_next     = m1_reg;
    m2_next     = m2_reg;
    ftype_next  = ftype_reg;
    fcnt_next   = fcnt_reg;
    rstd_next   = 1'b0;
    // Lock keys; other values leave the state alone
    if (reg_wr && reg_addr == ADDR_LOCK) begin
      if (reg_wdata == KEY_LOCK)   locked_next = 1'b1;
      if (reg_wdata == KEY_UNLOCK) locked_next = 1'b0;
    end
    // Masks
    // Mask writes are never blocked by the lock
    if (wr_st && reg_addr == ADDR_IRQ_ENABLE_PRIMARY) m0_next = reg_wdata;
    if (wr_st && reg_addr == ADDR_IRQ_ENABLE_SECONDARY) m1_next = reg_wdata;
    if (wr_st && reg_addr == ADDR_IRQ_ENABLE_TERTIARY) m2_next = reg_wdata;
    if (wr_st && reg_addr == ADDR_CKS_CTRL && reg_wdata[BIT_FORCE]) force_next = 1'b1;
    // Write-one clears come first so that new events win
    if (wr_st && reg_addr == ADDR_STAT0) st0_next = st0_reg & ~(reg_wdata & W1C_STAT0);
    if (wr_st && reg_addr == ADDR_STAT1) st1_next = st1_reg & ~reg_wdata;
    if (wr_st && reg_addr == ADDR_STAT2) st2_next = st2_reg & ~reg_wdata;
    st1_next = st1_next | secondary_events;
    st2_next = st2_next | tertiary_events;
    // Interval timer
    // Free running; a started run restarts it, so a forced run also
    // pushes the next scheduled run a full interval further out
    if (tmr_reg >= 32'(CKS_CYCLES - 1)) tmr_next = 32'h0;
    else                                tmr_next = tmr_reg + 32'h1;
    // Checksum engine
    // A run takes one cycle to start, one per register, then one to store
    case (state_reg)
      CKS_IDLE: begin
        if (force_reg || tmr_reg >= 32'(CKS_CYCLES - 1)) begin
          state_next = CKS_RUN;
          acc_next   = CKS_SEED;
          idx_next   = 5'h0;
          tmr_next   = 32'h0;
        end
      end
      CKS_RUN: begin
        acc_next = crc_step(acc_reg, cks_byte);
        if (idx_reg == 5'(NUM_CFG - 1)) state_next = CKS_DONE;
        else                            idx_next = idx_reg + 5'h1;
      end
      CKS_DONE: begin
        cks_next   = acc_reg;
        first_next = 1'b0;
        if (!first_reg && acc_reg != cks_reg) st0_next[BIT_CKS_CHG] = 1'b1;
        // A force write landing now starts another run rather than being lost
        if (!(wr_st && reg_addr == ADDR_CKS_CTRL && reg_wdata[BIT_FORCE]))
          force_next = 1'b0;
        st0_next[BIT_CKS_DONE] = 1'b1;
        state_next = CKS_IDLE;
      end
      default: state_next = CKS_IDLE;
    endcase
    // Event flags
    // Sticky flags are set after the write-one clears above, so an event
    // and its clear in the same cycle leave the flag set
    // Link ready only follows chip_ready once reset done has been seen
    if (rstd_reg) st0_next[BIT_RESET_DONE] = 1'b1;
    st0_next[BIT_LINK_READY] = chip_ready && !rstd_reg && (st0_reg[BIT_LINK_READY] ||
                               st0_reg[BIT_RESET_DONE] || !first_reg);
    if (link_err) begin
      st0_next[BIT_LINK_FAULT] = 1'b1;
      ftype_next = link_err_kind;
      if (fcnt_reg != 8'hFF) fcnt_next = fcnt_reg + 8'h1;
    end
    if (fuse_err) st0_next[BIT_FUSE_ERR] = 1'b1;
    s1x = st1_next & m1_next;
    s2x = st2_next & m2_next;
    st0_next[BIT_STAT1X] = |s1x;
    st0_next[BIT_STAT2X] = |s2x;
  end

  // Read mux and interrupt pin
  // Read data stands for one cycle after the strobe, then returns to zero
  // The pin looks at the registered flags, so it lags them by one cycle
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      if (reg_addr >= ADDR_CFG_FIRST && reg_addr < ADDR_LOCK)
        rdata_next = cfg_reg[5'(reg_addr - ADDR_CFG_FIRST)];
      else begin
        case (reg_addr)
          ADDR_LOCK:      rdata_next = locked_reg ? KEY_LOCK : KEY_UNLOCK;
          ADDR_CKS_CTRL:  rdata_next = {7'h00, force_reg};
          ADDR_CKS_HI:    rdata_next = cks_reg[15:8];
          ADDR_CKS_LO:    rdata_next = cks_reg[7:0];
          ADDR_STAT0:     rdata_next = st0_reg;
          ADDR_STAT1:     rdata_next = st1_reg;
          ADDR_STAT2:     rdata_next = st2_reg;
          ADDR_IRQ_ENABLE_PRIMARY:     rdata_next = m0_reg;
          ADDR_IRQ_ENABLE_SECONDARY:     rdata_next = m1_reg;
          ADDR_IRQ_ENABLE_TERTIARY:     rdata_next = m2_reg;
          ADDR_FLT_TYPE:  rdata_next = {4'h0, ftype_reg};
          ADDR_FLT_COUNT: rdata_next = fcnt_reg;
          default:        rdata_next = 8'h00;
        endcase
      end
    end
    irq_n_next = ~|(st0_reg & (m0_reg | NONMASKABLE));
  end

  // Register all state but the configuration entries
  // Reset leaves the force bit set so the reset default checksum is
  // loaded straight after release, without raising checksum changed
  always_ff @(posedge clk) begin
    if (reset) begin
      locked_reg <= 1'b0;
      force_reg  <= 1'b1;       // Compute reset default at once
      cks_reg    <= 16'h0000;
      acc_reg    <= CKS_SEED;
      idx_reg    <= 5'h0;
      first_reg  <= 1'b1;
      tmr_reg    <= 32'h0;
      state_reg  <= CKS_IDLE;
      st0_reg    <= 8'h00;
      st1_reg    <= 8'h00;
      st2_reg    <= 8'h00;
      m0_reg     <= MASK_RST;
      m1_reg     <= MASK_RST;
      m2_reg     <= MASK_RST;
      ftype_reg  <= 4'h0;
      fcnt_reg   <= 8'h00;
      rstd_reg   <= 1'b1;       // Marks the first cycle after release
      rdata_reg  <= 8'h00;
      irq_n_reg  <= 1'b1;
    end else begin
      locked_reg <= locked_next;
      force_reg  <= force_next;
      cks_reg    <= cks_next;
      acc_reg    <= acc_next;
      idx_reg    <= idx_next;
      first_reg  <= first_next;
      tmr_reg    <= tmr_next;
      state_reg  <= state_next;
      st0_reg    <= st0_next;
      st1_reg    <= st1_next;
      st2_reg    <= st2_next;
      m0_reg     <= m0_next;
      m1_reg     <= m1_next;
      m2_reg     <= m2_next;
      ftype_reg  <= ftype_next;
      fcnt_reg   <= fcnt_next;
      rstd_reg   <= rstd_next;
      rdata_reg  <= rdata_next;
      irq_n_reg  <= irq_n_next;
    end
  end

  // Outputs come straight from registers
  assign reg_rdata       = rdata_reg;
  assign burst_primary   = st0_reg;
  assign burst_secondary = st1_reg;
  assign irq_n           = irq_n_reg;
endmodule // cgs_guard

// ### design/cgs_pkg.sv
// Package with register map, field positions, reset values and timing for the guard block
package cgs_pkg;
  // Register word indices (register port address space)
  localparam logic [7:0] ADDR_CFG_FIRST    = 8'h01;  // First configuration register
  localparam logic [7:0] ADDR_CFG_PROT_END = 8'h18;  // Last write-protected register
  localparam logic [7:0] ADDR_LOCK         = 8'h1F;  // Lock control register
  localparam logic [7:0] ADDR_CKS_CTRL     = 8'h20;  // Checksum control
  localparam logic [7:0] ADDR_CKS_HI       = 8'h21;  // Checksum upper byte
  localparam logic [7:0] ADDR_CKS_LO       = 8'h22;  // Checksum lower byte
  localparam logic [7:0] ADDR_STAT0        = 8'h23;  // Primary event flags
  localparam logic [7:0] ADDR_STAT1        = 8'h24;  // Secondary event flags
  localparam logic [7:0] ADDR_STAT2        = 8'h25;  // Tertiary event flags
  localparam logic [7:0] ADDR_IRQ_ENABLE_PRIMARY        = 8'h26;  // Primary irq enables
  localparam logic [7:0] ADDR_IRQ_ENABLE_SECONDARY        = 8'h27;  // Secondary summary enables
  localparam logic [7:0] ADDR_IRQ_ENABLE_TERTIARY        = 8'h28;  // Tertiary summary enables
  localparam logic [7:0] ADDR_FLT_TYPE     = 8'h29;  // Barrier fault category
  localparam logic [7:0] ADDR_FLT_COUNT    = 8'h2A;  // Barrier fault tally
  // Lock keys
  localparam logic [7:0] KEY_LOCK   = 8'hD4;  // Enables protection
  localparam logic [7:0] KEY_UNLOCK = 8'h5E;  // Disables protection
  // Primary status bit positions
  localparam int BIT_LINK_FAULT = 0;  // Barrier link fault
  localparam int BIT_STAT1X     = 1;  // Secondary summary
  localparam int BIT_STAT2X     = 2;  // Tertiary summary
  localparam int BIT_CKS_CHG    = 3;  // Checksum changed
  localparam int BIT_LINK_READY = 4;  // Link ready
  localparam int BIT_RESET_DONE = 5;  // Reset complete
  localparam int BIT_FUSE_ERR   = 6;  // Fuse memory fault
  localparam int BIT_CKS_DONE   = 7;  // Checksum done
  // Checksum control bit positions
  localparam int BIT_FORCE = 0;  // Force immediate checksum
  // Flags that reach the pin regardless of the mask
  localparam logic [7:0] NONMASKABLE = 8'h60;
  // Sticky flags cleared by write one (summaries and ready are live)
  localparam logic [7:0] W1C_STAT0   = 8'hE9;
  // Reset values
  localparam logic [7:0] MASK_RST    = 8'h00;
  localparam logic [15:0] CKS_SEED   = 16'hFFFF;  // Checksum start value
  localparam logic [15:0] CKS_POLY   = 16'h1021;  // Checksum polynomial
  // Timing
  localparam int CLK_HZ         = 125_000_000;
  localparam int CKS_PERIOD_US  = 8000;          // About 8 ms
  localparam int CKS_PERIOD_CYC = (CLK_HZ / 1_000_000) * CKS_PERIOD_US;
  localparam int NUM_CFG        = 31;            // Registers 0x01..0x1F
endpackage : cgs_pkg

// ### tb/cgs_guard_props.sv
// Port-level checker for the guard block
`timescale 1ns/100ps
module cgs_guard_props
  import cgs_pkg::*;
#(
  parameter int CKS_CYCLES = 200  // Checksum interval
) (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] burst_primary,
  input wire logic [7:0] burst_secondary,
  input wire logic [7:0] cfg_out [NUM_CFG],
  input wire logic       chip_ready,
  input wire logic       link_err,
  input wire logic [3:0] link_err_kind,
  input wire logic       fuse_err,
  input wire logic [7:0] secondary_events,
  input wire logic [7:0] tertiary_events,
  input wire logic       irq_n
);
  logic lock_reg;   // Protection state seen from the bus
  logic lock_next;  // Next protection state
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Follow lock and unlock keys
  always_comb begin
    lock_next = lock_reg;
    if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == KEY_LOCK) lock_next = 1'b1;
    if (reg_wr && reg_addr == ADDR_LOCK && reg_wdata == KEY_UNLOCK) lock_next = 1'b0;
  end
  // Register the protection state
  always_ff @(posedge clk) begin
    lock_reg <= reset ? 1'b0 : lock_next;
  end
  chk_rst_flag: assert property ($fell(reset) |-> ##[1:3] burst_primary[BIT_RESET_DONE])
    else $error("reset done flag missing");
  chk_nmi_pin: assert property ((burst_primary[BIT_RESET_DONE] ||
    burst_primary[BIT_FUSE_ERR]) |-> ##[0:2] !irq_n)
    else $error("nonmaskable flag did not reach pin");
  chk_pin_idle: assert property ((burst_primary == 8'h00)[*3] |-> irq_n)
    else $error("pin low with no flag set");
  chk_lock_read: assert property ((reg_wr && reg_addr == ADDR_LOCK &&
    (reg_wdata == KEY_LOCK || reg_wdata == KEY_UNLOCK)) ##2 (reg_rd && reg_addr == ADDR_LOCK)
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("lock register readback wrong");
  chk_lock_hold: assert property ((lock_reg && reg_wr && reg_addr == 8'h05)
    |-> ##2 cfg_out[4] == $past(cfg_out[4], 2)) else $error("locked write took effect");
  chk_fault_flag: assert property (link_err |-> ##[1:2] burst_primary[BIT_LINK_FAULT])
    else $error("link fault flag missing");
  chk_force_done: assert property ((reg_wr && reg_addr == ADDR_CKS_CTRL &&
    reg_wdata[BIT_FORCE]) |-> ##[1:60] burst_primary[BIT_CKS_DONE]) else $error("no done flag");
  chk_ready_live: assert property ((!chip_ready)[*3] |-> !burst_primary[BIT_LINK_READY])
    else $error("ready flag without chip ready");
  chk_sec_seen: assert property ((secondary_events != 8'h00)
    |-> ##[1:2] (burst_secondary != 8'h00)) else $error("secondary flag not in long read");
  cover property (link_err);
  cover property (lock_reg && reg_wr && reg_addr == 8'h05);
  cover property (!irq_n ##1 irq_n);
endmodule : cgs_guard_props
bind cgs_guard cgs_guard_props #(.CKS_CYCLES(CKS_CYCLES)) u_props (.clk(clk), .reset(reset),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .burst_primary(burst_primary), .burst_secondary(burst_secondary),
  .cfg_out(cfg_out), .chip_ready(chip_ready), .link_err(link_err),
  .link_err_kind(link_err_kind), .fuse_err(fuse_err), .secondary_events(secondary_events),
  .tertiary_events(tertiary_events), .irq_n(irq_n));

// ### tb/cgs_host_model.sv
// Host model that drives the register port
`timescale 1ns/100ps
module cgs_host_model (
  input  wire logic       clk,        // Device clock
  output logic            reg_wr,     // Write strobe
  output logic            reg_rd,     // Read strobe
  output logic      [7:0] reg_addr,   // Register address
  output logic      [7:0] reg_wdata,  // Write data
  input  wire logic [7:0] reg_rdata   // Read data
);
  // Idle bus at time zero
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // One write taken at the next edge, then an idle cycle; data line is scrambled after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
    @(posedge clk);
    #1;
  endtask
  // One read; data is registered at the taking edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    d      = reg_rdata;
    @(posedge clk);
    #1;
  endtask
endmodule : cgs_host_model

// ### tb/cgs_guard_tb.sv
// Self-checking bench for the guard block
`timescale 1ns/100ps
module cgs_guard_tb;
  import cgs_pkg::*;
  localparam int CYC = 200;            // Shortened checksum interval
  logic        clk, reset, chip_ready; // Clock, reset, ready level
  logic        link_err, fuse_err;     // Fault events
  logic        reg_wr, reg_rd, irq_n;  // Strobes and pin
  logic [3:0]  link_err_kind;          // Fault category
  logic [7:0]  sec_ev, ter_ev, v, bp, bs, reg_addr, reg_wdata, reg_rdata;
  logic [7:0]  cfgo [NUM_CFG];         // Config contents from the design
  logic [7:0]  cfg [NUM_CFG];          // Expected config contents
  logic [15:0] sum;                    // Expected checksum
  int          num_errors, checks, cyc;
  cgs_guard #(.CKS_CYCLES(CYC)) dut (.clk(clk), .reset(reset), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .burst_primary(bp), .burst_secondary(bs), .cfg_out(cfgo), .chip_ready(chip_ready),
    .link_err(link_err), .link_err_kind(link_err_kind), .fuse_err(fuse_err),
    .secondary_events(sec_ev), .tertiary_events(ter_ev), .irq_n(irq_n));
  cgs_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // Clock at 8 ns
  always #4 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Read a register and compare the masked value
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    host.rd(a, v);
    chk(v & m, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One byte of the checksum, most significant bit first
  function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) c = (c[15] ^ b[i]) ? ((c << 1) ^ CKS_POLY) : (c << 1);
    return c;
  endfunction
  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    clk           = 1'b0;
    reset         = 1'b1;
    chip_ready    = 1'b0;
    link_err      = 1'b0;
    fuse_err      = 1'b0;
    link_err_kind = 4'h0;
    sec_ev        = 8'h00;
    ter_ev        = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    reset = 1'b0;
    // Reset default checksum: all registers zero, lock reads as unlock key
    sum = CKS_SEED;
    for (int i = 0; i < 30; i++) sum = crc8(sum, 8'h00);
    sum = crc8(sum, KEY_UNLOCK);
    tick(60);
    rdc(ADDR_STAT0, 8'h20, 8'h20);
    chk(irq_n, 1'b0);
    rdc(ADDR_CKS_HI, 8'hFF, sum[15:8]);
    rdc(ADDR_CKS_LO, 8'hFF, sum[7:0]);
    rdc(ADDR_STAT0, 8'h08, 8'h00);
    rdc(ADDR_LOCK, 8'hFF, KEY_UNLOCK);
    host.wr(ADDR_STAT0, 8'hFF);
    tick(3);
    chk(irq_n, 1'b1);
    for (int i = 1; i <= 30; i++) begin
      cfg[i-1] = i[7:0] ^ 8'hA5;
      host.wr(i[7:0], cfg[i-1]);
    end
    host.wr(ADDR_LOCK, KEY_UNLOCK);
    sum = CKS_SEED;
    for (int i = 0; i < 30; i++) sum = crc8(sum, cfg[i]);
    sum = crc8(sum, KEY_UNLOCK);
    tick(CYC + 50);
    rdc(ADDR_STAT0, 8'h08, 8'h08);
    // Clear changed and done so the forced run has to set done itself
    host.wr(ADDR_STAT0, 8'h88);
    host.wr(ADDR_CKS_CTRL, 8'h01);
    rdc(ADDR_CKS_CTRL, 8'h01, 8'h01);
    tick(60);
    rdc(ADDR_CKS_CTRL, 8'h01, 8'h00);
    rdc(ADDR_STAT0, 8'h88, 8'h80);
    rdc(ADDR_CKS_HI, 8'hFF, sum[15:8]);
    rdc(ADDR_CKS_LO, 8'hFF, sum[7:0]);
    host.wr(ADDR_LOCK, KEY_LOCK);
    rdc(ADDR_LOCK, 8'hFF, KEY_LOCK);
    host.wr(ADDR_LOCK, 8'h33);
    rdc(ADDR_LOCK, 8'hFF, KEY_LOCK);
    host.wr(8'h05, 8'h00);
    host.wr(8'h18, 8'h00);
    host.wr(8'h19, 8'h77);
    chk(cfgo[4], cfg[4]);
    chk(cfgo[23], cfg[23]);
    chk(cfgo[24], 8'h77);
    host.wr(ADDR_LOCK, KEY_UNLOCK);
    rdc(ADDR_LOCK, 8'hFF, KEY_UNLOCK);
    host.wr(8'h05, 8'h00);
    chk(cfgo[4], 8'h00);
    for (int k = 0; k < 2; k++) begin
      {link_err, link_err_kind} = 5'h19;
      tick(1);
      {link_err, link_err_kind} = 5'h06;
      tick(1);
    end
    rdc(ADDR_STAT0, 8'h01, 8'h01);
    rdc(ADDR_FLT_TYPE, 8'h0F, 8'h09);
    rdc(ADDR_FLT_COUNT, 8'hFF, 8'h02);
    chk(irq_n, 1'b1);
    host.wr(ADDR_IRQ_ENABLE_PRIMARY, 8'h01);
    tick(2);
    chk(irq_n, 1'b0);
    host.wr(ADDR_STAT0, 8'h01);
    tick(2);
    chk(irq_n, 1'b1);
    fuse_err = 1'b1;
    tick(1);
    fuse_err = 1'b0;
    tick(2);
    chk(irq_n, 1'b0);
    host.rd(ADDR_STAT0, v);
    chk(bp, v);
    host.wr(ADDR_STAT0, 8'h40);
    host.wr(ADDR_IRQ_ENABLE_SECONDARY, 8'h04);
    sec_ev = 8'h04;
    tick(1);
    sec_ev = 8'h00;
    tick(2);
    rdc(ADDR_STAT0, 8'h02, 8'h02);
    rdc(ADDR_STAT1, 8'hFF, 8'h04);
    chk(bs, 8'h04);
    host.wr(ADDR_STAT1, 8'h04);
    rdc(ADDR_STAT0, 8'h02, 8'h00);
    host.wr(ADDR_IRQ_ENABLE_TERTIARY, 8'h02);
    ter_ev = 8'h02;
    tick(1);
    ter_ev = 8'h00;
    tick(2);
    rdc(ADDR_STAT0, 8'h04, 8'h04);
    host.wr(ADDR_STAT2, 8'h02);
    rdc(ADDR_STAT2, 8'hFF, 8'h00);
    rdc(ADDR_STAT0, 8'h04, 8'h00);
    chip_ready = 1'b1;
    tick(3);
    rdc(ADDR_STAT0, 8'h10, 8'h10);
    rdc(8'h7F, 8'hFF, 8'h00);
    wrap_up();
  end
endmodule : cgs_guard_tb
